//--- oad_decode.sv
// What this block does
// - PC-relative target is counter minus two plus sign-extended 8-bit displacement.
// - Counter takes the relative sum only when branch condition holds, else sequential.
// - PC-relative word: opcode bits 0-7, signed displacement bits 8-15.
// - Non-indexed base mode adds base register to 8-bit displacement.
// - Base displacement is unsigned and zero-extended before adding.
// - Base register number is 2-bit code plus 12, so R12-R15.
// - Indexed base mode adds index register to base register, no displacement.
// - Index registers R1-R15; index zero selects the non-indexed variant.
// - Base word: opcode 0-5, base code 6-7, displacement or extension plus index.
// - Register-direct word: opcode 0-7, destination 8-11, source 12-15.
// - Memory direct/indirect take address from second word, bits 16-31.
// - Index field zero means non-indexed variant, non-zero means indexed.
// - Fixed immediate long: extension in bits 12-15, operand in second word.
// - Special words: opcode 0-7, two 4-bit special codes.
// - Indexed memory direct address is index register plus address field.
// - Indexable immediate long adds index register when index field non-zero.
// - Negative short immediate negates magnitude 1-16 into a 16-bit operand.
`timescale 1ns/10ps
`default_nettype none
module oad_decode
	import oad_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// Instruction and mode from the sequencer
	input wire logic i_decode_valid,
	input wire logic [15:0] i_first_word,
	input wire logic [15:0] i_second_word,
	input wire oad_pkg::oad_mode_t i_mode,
	input wire logic i_branch_taken,
	// Datapath register file and counter
	input wire logic [oad_pkg::REG_NUM*oad_pkg::WORD_W-1:0] i_gen_regs,
	input wire logic [15:0] i_instruction_counter,
	// Decoded outputs
	output logic o_result_valid,
	output oad_pkg::oad_fields_t o_fields,
	output oad_pkg::oad_result_t o_result,
	output logic o_counter_load,
	output logic [15:0] o_counter_next
);
	import oad_pkg::*;

	logic [15:0] gen_reg [REG_NUM];
	oad_fields_t next_fields;
	oad_result_t next_result;
	logic [3:0] idx_sel;
	logic [3:0] base_sel;
	logic idx_used;
	logic [15:0] idx_value;
	logic [15:0] base_value;
	logic [15:0] rel_target;
	logic [15:0] seq_next;

	genvar g;
	generate
		for (g = 0; g < REG_NUM; g++)
		begin : g_regs
			assign gen_reg[g] = i_gen_regs[g*WORD_W +: WORD_W];
		end
	endgenerate

	function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0];
	endfunction : add16

	// Field extraction; bit 0 of the layout is the word's MSB
	always_comb
	begin
		next_fields = '0;
		next_fields.opcode_field = i_first_word[OPC_HI:OPC_LO];
		next_fields.dest_reg_field = i_first_word[DEST_HI:DEST_LO];
		next_fields.source_reg_field = i_first_word[SRC_HI:SRC_LO];
		next_fields.opcode_extension_field = (i_mode == OAD_BASE_INDEXABLE)
			? i_first_word[DEST_HI:DEST_LO] : i_first_word[SRC_HI:SRC_LO];
		next_fields.base_reg_code = i_first_word[BASE_HI:BASE_LO];
		next_fields.unsigned_disp_field = i_first_word[DISP_HI:DISP_LO];
		next_fields.special_code_one = i_first_word[DEST_HI:DEST_LO];
		next_fields.special_code_two = i_first_word[SRC_HI:SRC_LO];
		if (i_mode == OAD_BASE_INDEXABLE || i_mode == OAD_BASE_DISP)
		begin
			next_fields.opcode_field = {2'b00, i_first_word[OPC_HI:OPC_B_LO]};
		end
	end

	assign idx_sel = i_first_word[SRC_HI:SRC_LO];
	assign idx_used = (idx_sel != INDEX_NONE);
	assign idx_value = idx_used ? gen_reg[idx_sel] : 16'h0000;
	assign base_sel = BASE_OFFSET + {2'b00, i_first_word[BASE_HI:BASE_LO]};
	assign base_value = gen_reg[base_sel];
	assign rel_target = add16(i_instruction_counter - PC_BACKSTEP,
		{{8{i_first_word[DISP_HI]}}, i_first_word[DISP_HI:DISP_LO]});
	assign seq_next = i_instruction_counter;

	always_comb
	begin
		next_result = '0;
		next_result.index_reg = idx_sel;
		next_result.base_reg = base_sel;
		next_result.branch_target = rel_target;
		case (i_mode)
			OAD_REG_DIRECT:
			begin
				next_result.operand_value = gen_reg[i_first_word[SRC_HI:SRC_LO]];
				next_result.operand_is_value = 1'b1;
			end
			OAD_MEM_DIRECT, OAD_MEM_INDIRECT:
			begin
				next_result.indexed = idx_used;
				next_result.operand_addr = add16(i_second_word, idx_value);
			end
			OAD_IMM_LONG_FIXED:
			begin
				next_result.operand_value = i_second_word;
				next_result.operand_is_value = 1'b1;
			end
			OAD_IMM_LONG_INDEXABLE:
			begin
				next_result.indexed = idx_used;
				next_result.operand_value = add16(i_second_word, idx_value);
				next_result.operand_is_value = 1'b1;
			end
			OAD_IMM_SHORT_POS:
			begin
				next_result.operand_value = {12'h000, idx_sel} + 16'h0001;
				next_result.operand_is_value = 1'b1;
			end
			OAD_IMM_SHORT_NEG:
			begin
				// Field 0 encodes magnitude 1, 15 encodes 16
				next_result.operand_value = 16'h0000 - ({12'h000, idx_sel} + 16'h0001);
				next_result.operand_is_value = 1'b1;
			end
			OAD_PC_RELATIVE:
			begin
				next_result.operand_addr = rel_target;
			end
			OAD_BASE_DISP:
			begin
				next_result.operand_addr = add16(base_value,
					{8'h00, i_first_word[DISP_HI:DISP_LO]});
			end
			OAD_BASE_INDEXABLE:
			begin
				next_result.indexed = idx_used;
				next_result.operand_addr = add16(base_value, idx_value);
			end
			OAD_SPECIAL:
			begin
				next_result.operand_is_value = 1'b0;
			end
			default:
			begin
				next_result.operand_is_value = 1'b0;
			end
		endcase
	end

	// Registered outputs keep datapath timing clean
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_result_valid <= 1'b0;
			o_fields <= '0;
			o_result <= '0;
		end
		else
		begin
			o_result_valid <= i_decode_valid;
			if (i_decode_valid)
			begin
				o_fields <= next_fields;
				o_result <= next_result;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_counter_load <= 1'b0;
			o_counter_next <= 16'h0000;
		end
		else
		begin
			// Untaken branches must not load, or a back-to-back step is lost
			o_counter_load <= i_decode_valid && (i_mode == OAD_PC_RELATIVE) && i_branch_taken;
			if (i_decode_valid && i_mode == OAD_PC_RELATIVE)
			begin
				o_counter_next <= i_branch_taken ? rel_target : seq_next;
			end
		end
	end

	// Checks read the raw word fields, so a slip in next_* logic shows up
	a_branch_taken_target: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_PC_RELATIVE && i_branch_taken
		|=> o_counter_load && o_counter_next == $past(rel_target))
		else $error("taken branch target wrong");
	a_branch_not_taken: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_PC_RELATIVE && !i_branch_taken
		|=> !o_counter_load && o_counter_next == $past(i_instruction_counter))
		else $error("untaken branch not sequential");
	a_load_only_relative: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		o_counter_load
		|-> $past(i_decode_valid && i_mode == OAD_PC_RELATIVE && i_branch_taken))
		else $error("counter load without taken branch");
	a_rel_sum_value: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_PC_RELATIVE
		|=> o_result.operand_addr == 16'($past(i_instruction_counter) - 16'd2
		+ {{8{$past(i_first_word[DISP_HI])}}, $past(i_first_word[DISP_HI:DISP_LO])}))
		else $error("relative sum wrong");
	a_base_sel_range: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid |=> o_result.base_reg >= 4'd12
		&& o_result.base_reg[1:0] == $past(i_first_word[BASE_HI:BASE_LO]))
		else $error("base register below twelve");
	a_base_disp_addr: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_BASE_DISP
		|=> o_result.operand_addr >= $past(base_value)
		|| o_result.operand_addr < {8'h00, $past(i_first_word[DISP_HI:DISP_LO])})
		else $error("base displacement not unsigned");
	a_base_disp_sum: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_BASE_DISP
		|=> !o_result.operand_is_value && o_result.operand_addr == 16'($past(base_value)
		+ {8'h00, $past(i_first_word[DISP_HI:DISP_LO])}))
		else $error("base displacement sum wrong");
	a_index_zero_plain: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_MEM_DIRECT && i_first_word[SRC_HI:SRC_LO] == INDEX_NONE
		|=> !o_result.indexed && o_result.operand_addr == $past(i_second_word))
		else $error("index zero not plain");
	a_direct_index_sum: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_MEM_DIRECT && i_first_word[SRC_HI:SRC_LO] != INDEX_NONE
		|=> o_result.indexed && o_result.operand_addr
		== 16'($past(i_second_word) + $past(idx_value)))
		else $error("direct index sum wrong");
	a_base_index_sum: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_BASE_INDEXABLE && i_first_word[SRC_HI:SRC_LO] != INDEX_NONE
		|=> o_result.indexed && o_result.operand_addr
		== 16'($past(base_value) + $past(idx_value)))
		else $error("base index sum wrong");
	a_base_index_zero: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_BASE_INDEXABLE
		&& i_first_word[SRC_HI:SRC_LO] == INDEX_NONE
		|=> !o_result.indexed && o_result.operand_addr == $past(base_value))
		else $error("base index zero not plain");
	a_imm_index_sum: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_IMM_LONG_INDEXABLE
		|=> o_result.operand_is_value && o_result.operand_value
		== 16'($past(i_second_word) + $past(idx_value)))
		else $error("indexable immediate wrong");
	a_short_neg_range: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_IMM_SHORT_NEG
		|=> o_result.operand_is_value && o_result.operand_value[15:4] == 12'hFFF
		&& o_result.operand_value[3:0] == ~$past(i_first_word[SRC_HI:SRC_LO]))
		else $error("short negative out of range");
	a_imm_fixed_value: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_IMM_LONG_FIXED
		|=> o_result.operand_value == $past(i_second_word)
		&& o_fields.opcode_extension_field == $past(i_first_word[SRC_HI:SRC_LO]))
		else $error("fixed immediate wrong");
	a_field_layout: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_REG_DIRECT
		|=> o_fields.opcode_field == $past(i_first_word[OPC_HI:OPC_LO])
		&& o_fields.dest_reg_field == $past(i_first_word[DEST_HI:DEST_LO])
		&& o_fields.source_reg_field == $past(i_first_word[SRC_HI:SRC_LO]))
		else $error("register direct fields wrong");
	a_special_codes: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_SPECIAL
		|=> !o_result.operand_is_value
		&& o_fields.special_code_one == $past(i_first_word[DEST_HI:DEST_LO])
		&& o_fields.special_code_two == $past(i_first_word[SRC_HI:SRC_LO]))
		else $error("special codes wrong");
	a_base_opcode_pad: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && (i_mode == OAD_BASE_DISP || i_mode == OAD_BASE_INDEXABLE)
		|=> o_fields.opcode_field == {2'b00, $past(i_first_word[OPC_HI:OPC_B_LO])})
		else $error("base opcode not padded");
	a_mem_indirect_addr: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_MEM_INDIRECT
		|=> !o_result.operand_is_value && o_result.operand_addr
		== 16'($past(i_second_word) + $past(idx_value)))
		else $error("indirect address wrong");
	a_relative_layout: assert property (@(posedge i_sys_clk)
		disable iff (!i_resetn)
		i_decode_valid && i_mode == OAD_PC_RELATIVE
		|=> o_fields.opcode_field == $past(i_first_word[OPC_HI:OPC_LO])
		&& o_fields.unsigned_disp_field == $past(i_first_word[DISP_HI:DISP_LO]))
		else $error("relative word fields wrong");
endmodule : oad_decode
`default_nettype wire

//--- oad_dp_model.sv
`timescale 1ns/10ps
`default_nettype none
module oad_dp_model
	import oad_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// From the sequencer and the decoder
	input wire logic i_decode_valid,
	input wire logic i_counter_load,
	input wire logic [15:0] i_counter_next,
	// Register file and counter
	output logic [oad_pkg::REG_NUM*oad_pkg::WORD_W-1:0] o_gen_regs,
	output logic [15:0] o_instruction_counter
);
	// Rn holds n times 1111 so R15 sits at the wrap edge
	always_comb
	begin
		for (int n = 0; n < REG_NUM; n++)
		begin
			o_gen_regs[n*WORD_W +: WORD_W] = 16'(n * 16'h1111);
		end
	end
	// A load wins over the sequential step
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_instruction_counter <= 16'h0010;
		else if (i_counter_load)
			o_instruction_counter <= i_counter_next;
		else if (i_decode_valid)
			o_instruction_counter <= o_instruction_counter + 16'h0002;
	end
endmodule : oad_dp_model
`default_nettype wire

//--- oad_pkg.sv
package oad_pkg;
	localparam int WORD_W = 16;
	localparam int REG_NUM = 16;
	localparam int REG_SEL_W = 4;
	// Bit 0 is the MSB in the instruction layout, so field 0..7 is [15:8]
	localparam int OPC_HI = 15;
	localparam int OPC_LO = 8;
	localparam int OPC_B_LO = 10;
	localparam int BASE_HI = 9;
	localparam int BASE_LO = 8;
	localparam int DEST_HI = 7;
	localparam int DEST_LO = 4;
	localparam int SRC_HI = 3;
	localparam int SRC_LO = 0;
	localparam int DISP_HI = 7;
	localparam int DISP_LO = 0;
	localparam logic [3:0] BASE_OFFSET = 4'hC;
	localparam logic [15:0] PC_BACKSTEP = 16'h0002;
	localparam logic [3:0] INDEX_NONE = 4'h0;

	typedef enum logic [3:0] {
		OAD_REG_DIRECT,
		OAD_MEM_DIRECT,
		OAD_MEM_INDIRECT,
		OAD_IMM_LONG_FIXED,
		OAD_IMM_LONG_INDEXABLE,
		OAD_IMM_SHORT_POS,
		OAD_IMM_SHORT_NEG,
		OAD_PC_RELATIVE,
		OAD_BASE_DISP,
		OAD_BASE_INDEXABLE,
		OAD_SPECIAL
	} oad_mode_t;

	typedef struct packed {
		logic [7:0] opcode_field;
		logic [3:0] dest_reg_field;
		logic [3:0] source_reg_field;
		logic [3:0] opcode_extension_field;
		logic [1:0] base_reg_code;
		logic [7:0] unsigned_disp_field;
		logic [3:0] special_code_one;
		logic [3:0] special_code_two;
	} oad_fields_t;

	typedef struct packed {
		logic [15:0] operand_addr;
		logic [15:0] operand_value;
		logic operand_is_value;
		logic indexed;
		logic [3:0] index_reg;
		logic [3:0] base_reg;
		logic [15:0] branch_target;
	} oad_result_t;
endpackage : oad_pkg

//--- tb_operand_address_decode.sv
`timescale 1ns/10ps
`default_nettype none
module tb_operand_address_decode;
	import oad_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic vld = 1'b0;
	logic [15:0] w1 = 16'h0000;
	logic [15:0] w2 = 16'h0000;
	oad_mode_t md = OAD_REG_DIRECT;
	logic tk = 1'b0;
	logic [REG_NUM*WORD_W-1:0] regs;
	logic [15:0] ctr;
	logic [15:0] ctr0;
	logic rv;
	logic ld;
	logic [15:0] nxt;
	oad_fields_t f;
	oad_result_t r;
	int bad_count = 0;
	int compares = 0;
	always #25 clk = ~clk;
	oad_decode i_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_decode_valid(vld),
		.i_first_word(w1), .i_second_word(w2), .i_mode(md), .i_branch_taken(tk),
		.i_gen_regs(regs), .i_instruction_counter(ctr), .o_result_valid(rv),
		.o_fields(f), .o_result(r), .o_counter_load(ld), .o_counter_next(nxt));
	oad_dp_model i_dp (.i_sys_clk(clk), .i_resetn(rstn), .i_decode_valid(vld),
		.i_counter_load(ld), .i_counter_next(nxt), .o_gen_regs(regs),
		.o_instruction_counter(ctr));
	function automatic logic [15:0] rg(input int n);
		return 16'(n * 16'h1111);
	endfunction : rg
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One request, then look at the one-cycle answer
	task automatic go(input oad_mode_t m, input logic [15:0] a, input logic [15:0] b,
		input logic t);
		@(posedge clk);
		vld <= 1'b1;
		w1 <= a;
		w2 <= b;
		md <= m;
		tk <= t;
		@(posedge clk);
		ctr0 = ctr;
		vld <= 1'b0;
		#1;
		chk(16'(rv), 16'h0001);
	endtask : go
	task automatic t_pc_rel();
		go(OAD_PC_RELATIVE, 16'h7405, 16'h0000, 1'b1);
		chk(r.branch_target, ctr0 + 16'h0003);
		chk(nxt, ctr0 + 16'h0003);
		chk(16'(ld), 16'h0001);
		chk(16'(f.opcode_field), 16'h0074);
		chk(16'(f.unsigned_disp_field), 16'h0005);
		go(OAD_PC_RELATIVE, 16'h7480, 16'h0000, 1'b1);
		chk(nxt, ctr0 - 16'h0082);
		go(OAD_PC_RELATIVE, 16'h74F0, 16'h0000, 1'b0);
		chk(nxt, ctr0);
		chk(16'(ld), 16'h0000);
		chk(r.branch_target, ctr0 - 16'h0012);
		@(posedge clk);
		#1;
		chk(16'(rv), 16'h0000);
		chk(nxt, ctr0);
		$display("done pc_rel");
	endtask : t_pc_rel
	task automatic t_base();
		for (int c = 0; c < 4; c++)
		begin
			go(OAD_BASE_DISP, {6'h2A, 2'(c), 8'hFF}, 16'h0000, 1'b0);
			chk(r.operand_addr, rg(c + 12) + 16'h00FF);
			chk(16'(r.base_reg), 16'(c + 12));
			chk(16'(f.opcode_field), 16'h002A);
			chk(16'(f.base_reg_code), 16'(c));
			chk(16'(f.unsigned_disp_field), 16'h00FF);
			chk(16'(r.operand_is_value), 16'h0000);
		end
		go(OAD_BASE_INDEXABLE, 16'h4537, 16'h0000, 1'b0);
		chk(r.operand_addr, rg(7) + rg(13));
		chk(16'(r.indexed), 16'h0001);
		chk(16'(f.opcode_extension_field), 16'h0003);
		go(OAD_BASE_INDEXABLE, 16'h4530, 16'h0000, 1'b0);
		chk(16'(r.indexed), 16'h0000);
		chk(r.operand_addr, rg(13));
		$display("done base");
	endtask : t_base
	task automatic t_fmt();
		go(OAD_REG_DIRECT, 16'hA15C, 16'h0000, 1'b0);
		chk(16'(f.opcode_field), 16'h00A1);
		chk(16'(f.dest_reg_field), 16'h0005);
		chk(16'(f.source_reg_field), 16'h000C);
		chk(r.operand_value, rg(12));
		chk(16'(ld), 16'h0000);
		go(OAD_SPECIAL, 16'hC39E, 16'h0000, 1'b0);
		chk(16'(f.opcode_field), 16'h00C3);
		chk(16'(r.operand_is_value), 16'h0000);
		chk(16'(f.special_code_one), 16'h0009);
		chk(16'(f.special_code_two), 16'h000E);
		$display("done formats");
	endtask : t_fmt
	task automatic t_mem();
		go(OAD_MEM_DIRECT, 16'h8030, 16'h1234, 1'b0);
		chk(r.operand_addr, 16'h1234);
		chk(16'(r.indexed), 16'h0000);
		go(OAD_MEM_DIRECT, 16'h8035, 16'hF000, 1'b0);
		chk(r.operand_addr, rg(5) + 16'hF000);
		go(OAD_MEM_INDIRECT, 16'h9430, 16'h4321, 1'b0);
		chk(r.operand_addr, 16'h4321);
		go(OAD_MEM_INDIRECT, 16'h943B, 16'h4321, 1'b0);
		chk(16'(r.index_reg), 16'h000B);
		chk(16'(r.indexed), 16'h0001);
		chk(r.operand_addr, rg(11) + 16'h4321);
		$display("done memory");
	endtask : t_mem
	task automatic t_imm();
		go(OAD_IMM_LONG_FIXED, 16'h4A19, 16'hBEEF, 1'b0);
		chk(16'(f.opcode_extension_field), 16'h0009);
		chk(r.operand_value, 16'hBEEF);
		chk(16'(r.operand_is_value), 16'h0001);
		go(OAD_IMM_LONG_INDEXABLE, 16'h8510, 16'h0100, 1'b0);
		chk(r.operand_value, 16'h0100);
		go(OAD_IMM_LONG_INDEXABLE, 16'h8513, 16'h0100, 1'b0);
		chk(r.operand_value, rg(3) + 16'h0100);
		for (int i = 0; i < 16; i += 15)
		begin
			go(OAD_IMM_SHORT_NEG, {12'h831, 4'(i)}, 16'h0000, 1'b0);
			chk(r.operand_value, 16'h0000 - 16'(i + 1));
			go(OAD_IMM_SHORT_POS, {12'h821, 4'(i)}, 16'h0000, 1'b0);
			chk(r.operand_value, 16'(i + 1));
		end
		$display("done immediate");
	endtask : t_imm
	// Mid-run reset must clear the valid, load, counter target and branch target outputs
	task automatic t_reset();
		go(OAD_PC_RELATIVE, 16'h7410, 16'h0000, 1'b1);
		@(posedge clk);
		rstn <= 1'b0;
		@(posedge clk);
		#1;
		chk(16'(rv), 16'h0000);
		chk(16'(ld), 16'h0000);
		chk(nxt, 16'h0000);
		chk(r.branch_target, 16'h0000);
		@(posedge clk);
		rstn <= 1'b1;
		go(OAD_PC_RELATIVE, 16'h7402, 16'h0000, 1'b1);
		chk(nxt, 16'h0010);
		$display("done reset");
	endtask : t_reset
	task automatic tally_and_finish();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_pc_rel();
		t_base();
		t_fmt();
		t_mem();
		t_imm();
		t_reset();
		tally_and_finish();
	end
	// About 24 requests of two cycles each; far more than enough
	initial
	begin
		repeat (2000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end
endmodule : tb_operand_address_decode
`default_nettype wire
